// ### bench/jesd_link_mode_assertions.sv
// Purpose: Concurrent checks on the link mode block ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Derived outputs other than the control bits field are only judged once reset has been gone a few edges.
`timescale 1ns/10ps

module link_cfg_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire jesd_link_mode_pkg::mode_param_t mode_params,
	input wire logic [8:0] frames_per_multiframe,
	input wire jesd_link_mode_pkg::ilas_t ilas_fields,
	input wire logic [63:0] lane_checksum,
	input wire logic [39:0] lane_ident,
	input wire logic [7:0] lane_active,
	input wire logic [7:0] lane_powerdown,
	input wire logic scrambler_en
);
	// ****************************************
	// Helper logic
	// ****************************************
	localparam logic [39:0] LID_MAP = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
	logic [1:0] run_r;
	logic [1:0] run_nxt;
	logic settled;
	logic [7:0] sum_base;
	logic [63:0] chk_exp;
	// Outputs lag reset release, so settle before judging them.
	assign run_nxt = (run_r == 2'h3) ? run_r : run_r + 2'h1;
	assign settled = (run_r == 2'h3);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= 2'h0;
		end else begin
			run_r <= run_nxt;
		end
	end
	// Common part of every lane checksum; the lane index is added per byte.
	assign sum_base = ilas_fields.did + ilas_fields.bid + ilas_fields.adjcnt + ilas_fields.adjdir
		+ ilas_fields.phadj + ilas_fields.scr + ilas_fields.l_m1 + ilas_fields.f_m1
		+ ilas_fields.k_m1 + ilas_fields.m_m1 + ilas_fields.cs + ilas_fields.n_m1
		+ ilas_fields.subclassv + ilas_fields.nprime_m1 + ilas_fields.jesdv + ilas_fields.s_m1
		+ ilas_fields.hd + ilas_fields.cf + ilas_fields.res1 + ilas_fields.res2;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			chk_exp[8*i +: 8] = sum_base + 8'(i);
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_fixed_fields: assert property (settled |-> {ilas_fields.bid, ilas_fields.adjcnt,
		ilas_fields.adjdir, ilas_fields.cf, ilas_fields.res1, ilas_fields.res2} == '0
		&& ilas_fields.jesdv == 3'h1 && ilas_fields.subclassv == 3'h1)
		else $error("fixed alignment field wrong");
	a_cs_zero: assert property (ilas_fields.cs == 2'h0)
		else $error("control bits field not zero");
	a_scr_field: assert property (settled |-> ilas_fields.scr == scrambler_en)
		else $error("scrambler field differs from enable");
	a_lane_checksum: assert property (settled ##0 $stable(ilas_fields)[*2]
		|-> lane_checksum == chk_exp) else $error("lane checksum wrong");
	a_lane_split: assert property (settled ##0 $stable(mode_params)[*2]
		|-> lane_active == 8'((9'h001 << mode_params.l) - 9'h001)
		&& lane_powerdown == ~lane_active) else $error("lane enables wrong");
	a_lane_ident: assert property (settled |-> lane_ident == LID_MAP)
		else $error("lane identifier wrong");
	a_k_wide: assert property (settled && mode_params.enc == jesd_link_mode_pkg::ENC_64B66B
		##0 $stable(mode_params)[*2] |-> int'(frames_per_multiframe) * int'(mode_params.f)
		== 256 * int'(mode_params.e)) else $error("wide-code frame count wrong");
	a_k_field: assert property (settled ##0 $stable(frames_per_multiframe)[*2]
		|-> ilas_fields.k_m1 == 8'(frames_per_multiframe - 9'h001))
		else $error("frame count field wrong");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule

bind jesd_link_mode_config link_cfg_checker link_cfg_checker_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .mode_params(mode_params),
	.frames_per_multiframe(frames_per_multiframe), .ilas_fields(ilas_fields),
	.lane_checksum(lane_checksum), .lane_ident(lane_ident), .lane_active(lane_active),
	.lane_powerdown(lane_powerdown), .scrambler_en(scrambler_en));

// ### bench/link_rx_model.sv
// Purpose: Behavioural link receiver that watches the lane setup.
// Assumes: Lanes are read on the receiver clock, same as the block clock.
// Notes: Only counts live lanes and decides whether streams need interleaving.
`timescale 1ns/10ps

module link_rx_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire jesd_link_mode_pkg::mode_param_t mode_params,
	input wire logic [7:0] lane_active,
	output logic [3:0] lanes_seen_r,
	output logic interleave_r
);
	// A powered-down lane carries nothing, so only live lanes are counted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lanes_seen_r <= 4'h0;
			interleave_r <= 1'b0;
		end else begin
			lanes_seen_r <= 4'($countones(lane_active));
			interleave_r <= (mode_params.m == mode_params.l);
		end
	end
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the link mode block.
// Assumes: Register map and reset values of the shared header.
// Notes: Every mode is programmed and all derived registers read back.
`timescale 1ns/10ps
`include "jesd_link_mode_cfg.svh"

module testbench;
	// ****************************************
	// Signals and expected mode table
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	jesd_link_mode_pkg::mode_param_t mode_params;
	jesd_link_mode_pkg::ilas_t ilas_fields;
	logic [8:0] frames_per_multiframe;
	logic [63:0] lane_checksum;
	logic [39:0] lane_ident;
	logic [7:0] lane_active, lane_powerdown;
	logic scrambler_en, rx_il;
	logic [3:0] rx_lanes;
	int failures = 0, tests_run = 0;
	localparam int L_T[16] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 8, 8, 8, 8, 8};
	localparam int M_T[16] = '{8, 4, 4, 4, 4, 4, 4, 4, 4, 4, 8, 8, 2, 8, 8, 8};
	localparam int F_T[16] = '{8, 2, 1, 5, 2, 2, 2, 1, 3, 1, 5, 8, 1, 5, 3, 3};
	localparam int S_T[16] = '{5, 2, 1, 4, 1, 1, 2, 1, 2, 2, 4, 5, 4, 4, 2, 2};
	localparam int N_T[16] = '{12, 12, 8, 10, 12, 8, 12, 8, 12, 8, 10, 12, 8, 10, 12, 12};
	localparam int E_T[16] = '{0, 0, 0, 0, 1, 1, 1, 1, 3, 0, 0, 0, 0, 0, 3, 3};
	localparam int H_T[16] = '{0, 1, 0, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	localparam int R_T[16] = '{256, 320, 320, 400, 528, 528, 264, 264, 396, 160, 200, 128, 80,
		100, 198, 99};
	localparam int X_T[16] = '{16000, 16000, 16000, 13728, 10400, 10400, 16000, 16000, 13867,
		16000, 16000, 16000, 16000, 16000, 16000, 16000};

	// Five-nanosecond clock.
	always #2.5 aclk = ~aclk;

	jesd_link_mode_config jesd_link_mode_config_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mode_params(mode_params),
		.frames_per_multiframe(frames_per_multiframe), .ilas_fields(ilas_fields),
		.lane_checksum(lane_checksum), .lane_ident(lane_ident), .lane_active(lane_active),
		.lane_powerdown(lane_powerdown), .scrambler_en(scrambler_en));
	link_rx_model link_rx_model_inst (.aclk(aclk), .aresetn(aresetn), .mode_params(mode_params),
		.lane_active(lane_active), .lanes_seen_r(rx_lanes), .interleave_r(rx_il));

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Handshakes are judged mid-cycle so the edge they refer to is never raced.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
		output logic [1:0] resp);
		logic aw_h, w_h, b_h;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b_h = 1'b0;
		while (!b_h) begin
			@(negedge aclk);
			aw_h = s_axi_awvalid && s_axi_awready;
			w_h = s_axi_wvalid && s_axi_wready;
			b_h = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_h) s_axi_awvalid <= 1'b0;
			if (w_h) s_axi_wvalid <= 1'b0;
			if (b_h) s_axi_bready <= 1'b0;
		end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_h, r_h;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r_h = 1'b0;
		while (!r_h) begin
			@(negedge aclk);
			ar_h = s_axi_arvalid && s_axi_arready;
			r_h = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_h) s_axi_arvalid <= 1'b0;
			if (r_h) s_axi_rready <= 1'b0;
		end
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(r, `CFG_RESP_OKAY);
		chk(d, exp);
	endtask
	task automatic summarize;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	// A hang costs one mismatch and ends the run.
	initial begin
		#50000;
		failures++;
		summarize();
	end
	// Reset values, refused accesses, then every mode.
	initial begin
		int k, act, base;
		logic [7:0] did;
		logic [1:0] resp;
		logic [31:0] d;
		logic [63:0] cs_exp;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rchk(`CFG_OFF_CTRL, 32'h0);
		rchk(`CFG_OFF_KM1, 32'h1F);
		chk(frames_per_multiframe, 9'h020);
		wr(`CFG_OFF_PARAM0, 32'hFFFF_FFFF, 4'hF, resp);
		chk(resp, `CFG_RESP_SLVERR);
		rd(8'h40, d, resp);
		chk({resp, d}, {`CFG_RESP_SLVERR, 32'h0});
		wr(`CFG_OFF_CTRL, 32'h0000_5A13, 4'h1, resp);
		rchk(`CFG_OFF_CTRL, 32'h13);
		chk(ilas_fields.did, 8'h00);
		for (int md = 0; md < 16; md++) begin
			did = 8'h3C ^ 8'(md * 17);
			wr(`CFG_OFF_KM1, 32'(md * 16 + 3), 4'hF, resp);
			wr(`CFG_OFF_CTRL, {16'h0, did, 3'h0, md[0], md[3:0]}, 4'hF, resp);
			chk(resp, `CFG_RESP_OKAY);
			k = (E_T[md] != 0) ? 256 * E_T[md] / F_T[md] : md * 16 + 4;
			act = (1 << L_T[md]) - 1;
			rchk(`CFG_OFF_PARAM0, L_T[md] + (M_T[md] << 8) + (F_T[md] << 16) + (S_T[md] << 24));
			rchk(`CFG_OFF_PARAM1, N_T[md] * 257 + (H_T[md] << 16) + ((E_T[md] != 0) << 17) + (E_T[md] << 18));
			rchk(`CFG_OFF_PARAM2, k + (R_T[md] << 16));
			rchk(`CFG_OFF_CLKRANGE, 5000 + (X_T[md] << 16));
			rchk(`CFG_OFF_LANES, act + ((255 - act) << 8));
			base = did + md[0] + L_T[md] + F_T[md] + k + M_T[md] + 2 * N_T[md] + S_T[md] + H_T[md] - 5;
			for (int i = 0; i < 8; i++) begin
				cs_exp[8*i +: 8] = 8'(base + i);
			end
			rchk(`CFG_OFF_CHK_LO, cs_exp[31:0]);
			rchk(`CFG_OFF_CHK_HI, cs_exp[63:32]);
			chk({ilas_fields.did, ilas_fields.scr, scrambler_en}, {did, md[0], md[0]});
			chk({ilas_fields.cs, ilas_fields.jesdv, ilas_fields.subclassv, ilas_fields.cf}, 13'h0120);
			chk({rx_lanes, rx_il}, {4'(L_T[md]), 1'(M_T[md] == L_T[md])});
		end
		summarize();
	end
endmodule

// ### design/jesd_link_mode_config.sv
// Purpose: Derives the output link transport configuration from one mode selection.
// Assumes: AXI4-Lite register access, one clock, synchronous active-low reset.
// Notes: All derived outputs are registered and follow a register write one cycle late.
//
// Behaviour
// - Fixed alignment fields zero; revision, subclass one.
// - Control bits per sample always sent zero.
// - Device identifier from user setting, every lane.
// - Checksum is field sum modulo 256.
// - 8B/10B K equals stored value plus one.
// - Mode 0: 12-bit, eight lanes, R=8.
// - Mode 1: 12-bit, six lanes, HD=1.
// - Mode 2: 8-bit, four lanes, R=10.
// - Mode 3: 10-bit, four lanes, R=12.5.
// - Modes 4, 5: 64B/66B, R=16.5.
// - Modes 6, 7: 64B/66B, R=8.25.
// - Mode 8: 64B/66B, four lanes, E=3.
// - Modes 9, 10: 8B/10B, eight lanes.
// - Modes 11 to 13: two-channel eight-lane.
// - Mode 14: 64B/66B eight lanes, R=6.1875.
// - Mode 15: two-channel 64B/66B, R=3.09375.
// - 64B/66B K is 256 times E over F.
// - Use lowest lanes, power down the rest.
// - Lane identifier equals lane index.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "jesd_link_mode_cfg.svh"

module jesd_link_mode_config (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output jesd_link_mode_pkg::mode_param_t mode_params,
	output logic [8:0] frames_per_multiframe,
	output jesd_link_mode_pkg::ilas_t ilas_fields,
	output logic [63:0] lane_checksum,
	output logic [39:0] lane_ident,
	output logic [7:0] lane_active,
	output logic [7:0] lane_powerdown,
	output logic scrambler_en
);

	// ****************************************
	// Software settings
	// ****************************************
	logic [3:0] link_format_select_r;
	logic scr_r;
	logic [7:0] did_r;
	logic [7:0] frames_per_multiframe_minus_one_r;

	// ****************************************
	// AXI4-Lite write channel state
	// ****************************************
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	// Address and data are accepted independently; each is refused while
	// already held or while a response waits, so only one write is open.
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// A side is taken at the edge where its valid meets its ready.
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held_r && w_held_r;

	// Write decode against the held address.
	wire wr_ctrl = wr_fire && (aw_addr_r == `CFG_OFF_CTRL);
	wire wr_km1 = wr_fire && (aw_addr_r == `CFG_OFF_KM1);
	// Status words are read-only, so a write to them is refused.
	wire wr_ro = (aw_addr_r == `CFG_OFF_PARAM0) ||
		(aw_addr_r == `CFG_OFF_PARAM1) ||
		(aw_addr_r == `CFG_OFF_PARAM2) ||
		(aw_addr_r == `CFG_OFF_CLKRANGE) ||
		(aw_addr_r == `CFG_OFF_LANES) ||
		(aw_addr_r == `CFG_OFF_CHK_LO) ||
		(aw_addr_r == `CFG_OFF_CHK_HI);
	wire wr_mapped = (aw_addr_r == `CFG_OFF_CTRL) || (aw_addr_r == `CFG_OFF_KM1) || wr_ro;

	// Byte-lane merge of the write data over the current register image.
	wire [31:0] ctrl_img = {16'h0000, did_r, 3'h0, scr_r, link_format_select_r};
	wire [31:0] km1_img = {24'h000000, frames_per_multiframe_minus_one_r};
	// Bytes without a strobe keep their stored value.
	logic [31:0] ctrl_new;
	logic [31:0] km1_new;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			ctrl_new[b*8 +: 8] = w_strb_r[b] ? w_data_r[b*8 +: 8] : ctrl_img[b*8 +: 8];
			km1_new[b*8 +: 8] = w_strb_r[b] ? w_data_r[b*8 +: 8] : km1_img[b*8 +: 8];
		end
	end

	// Holding registers for the two halves of a write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (aw_take) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (w_take) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	// Write response; read-only and unmapped words answer SLVERR and change nothing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `CFG_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_mapped && !wr_ro) ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Mode selection, scrambler enable and identifier.
	// Every 4-bit selection is a defined mode, so no legality filter is needed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_format_select_r <= `CFG_RST_MODE;
			scr_r <= `CFG_RST_SCR;
			did_r <= `CFG_RST_DID;
		end else if (wr_ctrl) begin
			link_format_select_r <= ctrl_new[`CFG_CTRL_MODE_LSB +: 4];
			scr_r <= ctrl_new[`CFG_CTRL_SCR_BIT];
			did_r <= ctrl_new[`CFG_CTRL_DID_LSB +: 8];
		end
	end

	// Multiframe length setting; stored whatever the mode, used only by 8B/10B modes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frames_per_multiframe_minus_one_r <= `CFG_RST_KM1;
		end else if (wr_km1) begin
			frames_per_multiframe_minus_one_r <= km1_new[7:0];
		end
	end

	// ****************************************
	// Mode derivation
	// ****************************************
	jesd_link_mode_pkg::mode_param_t prm;

	// Pure lookup; its result is registered with every other output.
	jesd_mode_table u_table (
		.sel(link_format_select_r),
		.prm(prm)
	);

	// The coding family decides where K comes from.
	wire is64 = (prm.enc == jesd_link_mode_pkg::ENC_64B66B);

	// K in 64B/66B modes comes from E and F only; the divisor is 1 to 8 so the
	// divider stays small.
	wire [9:0] k64_full = (`CFG_K64_NUMER * {8'h00, prm.e}) / {6'h00, prm.f};
	wire [8:0] k8_full = {1'b0, frames_per_multiframe_minus_one_r} + 9'h001;
	wire [8:0] k_sel = is64 ? k64_full[8:0] : k8_full;
	wire [7:0] k_m1_sel = is64 ? 8'(k64_full - 10'h001) : frames_per_multiframe_minus_one_r;

	// Common alignment fields; the lane identifier is added per lane.
	jesd_link_mode_pkg::ilas_t ilas_nxt;
	always_comb begin
		ilas_nxt = '0;
		ilas_nxt.did = did_r;
		ilas_nxt.scr = scr_r;
		ilas_nxt.l_m1 = 5'({1'b0, prm.l} - 5'h01);
		ilas_nxt.f_m1 = 8'({4'h0, prm.f} - 8'h01);
		ilas_nxt.k_m1 = k_m1_sel;
		ilas_nxt.m_m1 = 8'({4'h0, prm.m} - 8'h01);
		ilas_nxt.cs = 2'h0;
		ilas_nxt.n_m1 = 5'({1'b0, prm.n} - 5'h01);
		ilas_nxt.subclassv = `CFG_SUBCLASSV;
		ilas_nxt.nprime_m1 = 5'({1'b0, prm.nprime} - 5'h01);
		ilas_nxt.jesdv = `CFG_JESDV;
		ilas_nxt.s_m1 = 5'({2'h0, prm.s} - 5'h01);
		ilas_nxt.hd = prm.hd;
	end

	// Sum of every field except lane identifier and checksum, kept at 8 bits.
	// The cast drops the carry, which gives the modulo the receiver expects.
	wire [7:0] base_sum = 8'(ilas_nxt.did + ilas_nxt.bid + ilas_nxt.adjcnt +
		ilas_nxt.adjdir + ilas_nxt.phadj + ilas_nxt.scr +
		ilas_nxt.l_m1 + ilas_nxt.f_m1 + ilas_nxt.k_m1 +
		ilas_nxt.m_m1 + ilas_nxt.cs + ilas_nxt.n_m1 +
		ilas_nxt.subclassv + ilas_nxt.nprime_m1 +
		ilas_nxt.jesdv + ilas_nxt.s_m1 + ilas_nxt.hd +
		ilas_nxt.cf + ilas_nxt.res1 +
		ilas_nxt.res2);

	// ****************************************
	// Per-lane identity, checksum and power
	// ****************************************
	logic [63:0] checksum_nxt;
	logic [39:0] ident_nxt;
	logic [7:0] active_nxt;

	// One lane per pass; its index is its identifier and checksum offset.
	genvar ln;
	generate
		for (ln = 0; ln < `CFG_NUM_LANES; ln++) begin : g_lane
			assign ident_nxt[ln*5 +: 5] = 5'(ln);
			assign checksum_nxt[ln*8 +: 8] = 8'(base_sum + 8'(ln));
			assign active_nxt[ln] = (4'(ln) < prm.l);
		end
	endgenerate

	// Registered outputs; a new mode reaches every output on the same edge,
	// so lanes never see a mixed configuration.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_params <= '0;
			frames_per_multiframe <= 9'h000;
			ilas_fields <= '0;
			lane_checksum <= 64'h0000000000000000;
			lane_ident <= 40'h0000000000;
			lane_active <= 8'h00;
			lane_powerdown <= 8'hFF;
			scrambler_en <= 1'b0;
		end else begin
			mode_params <= prm;
			frames_per_multiframe <= k_sel;
			ilas_fields <= ilas_nxt;
			lane_checksum <= checksum_nxt;
			lane_ident <= ident_nxt;
			lane_active <= active_nxt;
			lane_powerdown <= ~active_nxt;
			scrambler_en <= scr_r;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// A new address waits until the previous answer has been taken.
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Address bits below the word are ignored.
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};

	// Read images; status words show the registered outputs, not the next values.
	wire [31:0] p0_img = {5'h00, mode_params.s,
		4'h0, mode_params.f,
		4'h0, mode_params.m,
		4'h0, mode_params.l};
	wire [31:0] p1_img = {12'h000, mode_params.e,
		mode_params.enc, mode_params.hd,
		4'h0, mode_params.nprime,
		4'h0, mode_params.n};
	wire [31:0] p2_img = {6'h00, mode_params.r_x32, 7'h00, frames_per_multiframe};
	wire [31:0] clk_img = {1'b0, mode_params.fmax_x10, 1'b0, mode_params.fmin_x10};
	wire [31:0] lanes_img = {16'h0000, lane_powerdown, lane_active};

	// Read decode; an unmapped word answers SLVERR with zero data.
	logic [31:0] rd_word;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (ra)
			`CFG_OFF_CTRL: rd_word = ctrl_img;
			`CFG_OFF_KM1: rd_word = km1_img;
			`CFG_OFF_PARAM0: rd_word = p0_img;
			`CFG_OFF_PARAM1: rd_word = p1_img;
			`CFG_OFF_PARAM2: rd_word = p2_img;
			`CFG_OFF_CLKRANGE: rd_word = clk_img;
			`CFG_OFF_LANES: rd_word = lanes_img;
			`CFG_OFF_CHK_LO: rd_word = lane_checksum[31:0];
			`CFG_OFF_CHK_HI: rd_word = lane_checksum[63:32];
			default: begin
				rd_word = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read answer one cycle after the address is taken; held until accepted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `CFG_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_hit ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule

// ### design/jesd_mode_table.sv
// Purpose: Lookup of the transport parameters for each link format selection.
// Assumes: All sixteen selections are defined modes.
// Notes: Pure combinational table.
`timescale 1ns/10ps

module jesd_mode_table (
	input wire logic [3:0] sel,
	output jesd_link_mode_pkg::mode_param_t prm
);

	// ****************************************
	// Table
	// ****************************************
	localparam jesd_link_mode_pkg::link_enc_t E8 = jesd_link_mode_pkg::ENC_8B10B;
	localparam jesd_link_mode_pkg::link_enc_t E64 = jesd_link_mode_pkg::ENC_64B66B;

	// Fields: enc, N, N', L, M, F, S, HD, E, R*32, fmin*10, fmax*10.
	always_comb begin
		unique case (sel)
			4'h0: prm = {E8, 4'hC, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 1'b0, 2'h0, 10'h100, 15'h1388, 15'h3E80};
			4'h1: prm = {E8, 4'hC, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 1'b1, 2'h0, 10'h140, 15'h1388, 15'h3E80};
			4'h2: prm = {E8, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 1'b0, 2'h0, 10'h140, 15'h1388, 15'h3E80};
			4'h3: prm = {E8, 4'hA, 4'hA, 4'h4, 4'h4, 4'h5, 3'h4, 1'b0, 2'h0, 10'h190, 15'h1388, 15'h35A0};
			4'h4: prm = {E64, 4'hC, 4'hC, 4'h3, 4'h4, 4'h2, 3'h1, 1'b1, 2'h1, 10'h210, 15'h1388, 15'h28A0};
			4'h5: prm = {E64, 4'h8, 4'h8, 4'h2, 4'h4, 4'h2, 3'h1, 1'b0, 2'h1, 10'h210, 15'h1388, 15'h28A0};
			4'h6: prm = {E64, 4'hC, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 1'b1, 2'h1, 10'h108, 15'h1388, 15'h3E80};
			4'h7: prm = {E64, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 1'b0, 2'h1, 10'h108, 15'h1388, 15'h3E80};
			4'h8: prm = {E64, 4'hC, 4'hC, 4'h4, 4'h4, 4'h3, 3'h2, 1'b0, 2'h3, 10'h18C, 15'h1388, 15'h362B};
			4'h9: prm = {E8, 4'h8, 4'h8, 4'h8, 4'h4, 4'h1, 3'h2, 1'b0, 2'h0, 10'h0A0, 15'h1388, 15'h3E80};
			4'hA: prm = {E8, 4'hA, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 1'b0, 2'h0, 10'h0C8, 15'h1388, 15'h3E80};
			4'hB: prm = {E8, 4'hC, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 1'b0, 2'h0, 10'h080, 15'h1388, 15'h3E80};
			4'hC: prm = {E8, 4'h8, 4'h8, 4'h8, 4'h2, 4'h1, 3'h4, 1'b0, 2'h0, 10'h050, 15'h1388, 15'h3E80};
			4'hD: prm = {E8, 4'hA, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 1'b0, 2'h0, 10'h064, 15'h1388, 15'h3E80};
			4'hE: prm = {E64, 4'hC, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 1'b0, 2'h3, 10'h0C6, 15'h1388, 15'h3E80};
			4'hF: prm = {E64, 4'hC, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 1'b0, 2'h3, 10'h063, 15'h1388, 15'h3E80};
		endcase
	end

endmodule

// ### shared/jesd_link_mode_cfg.svh
// Purpose: Register map, field positions and fixed field values for the link mode block.
// Assumes: Included by the testbench and by jesd_link_mode_config by its bare name.
// Notes: Definitions only.
`ifndef JESD_LINK_MODE_CFG_SVH
`define JESD_LINK_MODE_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CFG_OFF_CTRL 8'h00
`define CFG_OFF_KM1 8'h04
`define CFG_OFF_PARAM0 8'h08
`define CFG_OFF_PARAM1 8'h0C
`define CFG_OFF_PARAM2 8'h10
`define CFG_OFF_CLKRANGE 8'h14
`define CFG_OFF_LANES 8'h18
`define CFG_OFF_CHK_LO 8'h1C
`define CFG_OFF_CHK_HI 8'h20

// ****************************************
// Field positions
// ****************************************
`define CFG_CTRL_MODE_LSB 0
`define CFG_CTRL_SCR_BIT 4
`define CFG_CTRL_DID_LSB 8
`define CFG_P1_HD_BIT 16
`define CFG_P1_ENC_BIT 17
`define CFG_P1_E_LSB 18
`define CFG_P2_R_LSB 16
`define CFG_CLK_MAX_LSB 16
`define CFG_LANES_PD_LSB 8

// ****************************************
// Reset values and fixed field values
// ****************************************
`define CFG_RST_MODE 4'h0
`define CFG_RST_SCR 1'b0
`define CFG_RST_DID 8'h00
`define CFG_RST_KM1 8'h1F
`define CFG_JESDV 3'h1
`define CFG_SUBCLASSV 3'h1
`define CFG_NUM_LANES 8
`define CFG_K64_NUMER 10'h100
`define CFG_RESP_OKAY 2'h0
`define CFG_RESP_SLVERR 2'h2

`endif

// ### shared/jesd_link_mode_pkg.sv
// Purpose: Types shared by the link mode block and its mode table.
// Assumes: Field widths follow the alignment sequence layout.
// Notes: Numbers live in jesd_link_mode_cfg.svh.
package jesd_link_mode_pkg;

	typedef enum logic {ENC_8B10B, ENC_64B66B} link_enc_t;

	// Per-mode transport parameters; R is scaled by 32, clock range by 10 (MHz).
	typedef struct packed {
		link_enc_t enc;
		logic [3:0] n;
		logic [3:0] nprime;
		logic [3:0] l;
		logic [3:0] m;
		logic [3:0] f;
		logic [2:0] s;
		logic hd;
		logic [1:0] e;
		logic [9:0] r_x32;
		logic [14:0] fmin_x10;
		logic [14:0] fmax_x10;
	} mode_param_t;

	// Alignment sequence fields, count fields carried as value minus one.
	typedef struct packed {
		logic [7:0] did;
		logic [3:0] bid;
		logic [3:0] adjcnt;
		logic adjdir;
		logic phadj;
		logic scr;
		logic [4:0] l_m1;
		logic [7:0] f_m1;
		logic [7:0] k_m1;
		logic [7:0] m_m1;
		logic [1:0] cs;
		logic [4:0] n_m1;
		logic [2:0] subclassv;
		logic [4:0] nprime_m1;
		logic [2:0] jesdv;
		logic [4:0] s_m1;
		logic hd;
		logic [4:0] cf;
		logic [7:0] res1;
		logic [7:0] res2;
	} ilas_t;

endpackage
